// File: src/setpoint_pkg.sv
// Package with constants, enumerations and carrier types for the set-value and output block.
package setpoint_pkg;

	// ==========================================================
	// Register map (byte addresses, one 32-bit word each)
	// ==========================================================
	localparam logic [7:0] CTRL_ADDR      = 8'h00;
	localparam logic [7:0] FIXED_ADDR     = 8'h04;
	localparam logic [7:0] MAXSPD_ADDR    = 8'h08;
	localparam logic [7:0] FDELAY_ADDR    = 8'h0C;
	localparam logic [7:0] STATUS_ADDR    = 8'h10;
	localparam logic [7:0] PERIOD_ADDR    = 8'h14;
	localparam logic [7:0] DEMAND_ADDR    = 8'h18;

	// ==========================================================
	// Control field positions
	// ==========================================================
	localparam int CTRL_SRC_LSB   = 0;   // Two bits: set-value source.
	localparam int CTRL_QS_LSB    = 2;   // Two bits: quick-stop function.
	localparam int CTRL_SENSLESS  = 4;
	localparam int CTRL_AHALL     = 5;
	localparam int CTRL_VOLTMODE  = 6;
	localparam int CTRL_FAULTOUT  = 7;
	localparam int CTRL_LINES6    = 8;
	localparam int CTRL_PLCLEVEL  = 9;
	localparam int CTRL_BRAKE     = 10;
	localparam int CTRL_WIDTH     = 11;

	// ==========================================================
	// Modes
	// ==========================================================
	localparam logic [1:0] SRC_FIXED  = 2'h0;
	localparam logic [1:0] SRC_ANALOG = 2'h1;
	localparam logic [1:0] SRC_PWM    = 2'h2;
	localparam logic [1:0] QS_NONE    = 2'h0;
	localparam logic [1:0] QS_NORMAL  = 2'h1;
	localparam logic [1:0] QS_INVERT  = 2'h2;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 11'h0_101; // Analog, six lines.
	localparam logic [15:0] FIXED_RESET  = 16'h0_3E8;
	localparam logic [15:0] MAXSPD_RESET = 16'h0_FA0;
	localparam logic [23:0] FDELAY_RESET = 24'h00_0000;

	// ==========================================================
	// Input thresholds in millivolts and duty thresholds
	// ==========================================================
	localparam logic [13:0] QS_STOP_MV     = 14'd150;
	localparam logic [13:0] QS_START_MV    = 14'd300;
	localparam logic [13:0] QS_START_SL_MV = 14'd500;
	localparam logic [13:0] QSI_RUN_MV     = 14'd2000;
	localparam logic [13:0] QSI_STOP_MV    = 14'd2400;
	localparam logic [13:0] FULL_SCALE_MV  = 14'd10000;
	localparam logic [9:0]  DUTY_STOP_PM   = 10'd20;   // 2.0 percent in per mille.
	localparam logic [9:0]  DUTY_START_PM  = 10'd30;   // 3.0 percent in per mille.
	localparam logic [9:0]  PER_MILLE      = 10'd1000;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_MHZ        = 125;
	localparam int PWM_MIN_HZ     = 500;
	localparam int PWM_MAX_CYCLES = CLK_MHZ * 1000000 / PWM_MIN_HZ;
	localparam int PWM_CNT_W      = $clog2(PWM_MAX_CYCLES + 1);
	localparam int STEP_CNT_W     = 24;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {PH_STOP, PH_FIELD, PH_CLOSED} phase_type;

	typedef struct packed {
		logic                   brake;
		logic                   plc_level;
		logic                   lines6;
		logic                   fault_out;
		logic                   volt_mode;
		logic                   analog_hall;
		logic                   sensorless;
		logic [1:0]             qs_mode;
		logic [1:0]             src;
	} ctrl_type;

	typedef struct packed {
		logic [15:0] speed;
		logic [15:0] voltage_mv;
		logic        run;
		logic        brake;
		logic        four_quadrant;
		logic        rotating_field;
	} demand_type;

endpackage

// File: src/bldc_setpoint_and_output_logic.sv
// Set-value selection, run/stop decision and digital output for a brushless speed controller.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bldc_setpoint_and_output_logic
	import setpoint_pkg::*;
#(
	parameter int          STEPS_PER_REV = 12,      // Commutation steps per mechanical turn.
	parameter logic [15:0] FIELD_SPEED   = 16'h0_1F4 // Demand below which sensorless uses a field.
)
(
	input  wire logic        pclk,                  // System clock, 125 MHz.
	input  wire logic        presetn,               // Asynchronous reset, active low.
	input  wire logic        psel,                  // APB select.
	input  wire logic        penable,               // APB enable.
	input  wire logic        pwrite,                // APB direction.
	input  wire logic [7:0]  paddr,                 // APB byte address.
	input  wire logic [31:0] pwdata,                // APB write data.
	output logic      [31:0] prdata,                // APB read data.
	output logic             pready,                // APB ready.
	output logic             pslverr,               // APB error on unmapped address.
	input  wire logic [13:0] setpoint_input_voltage, // Set-value input in millivolts.
	input  wire logic        setpoint_open,         // Set-value input is unconnected.
	input  wire logic [15:0] supply_voltage_mv,     // Motor supply in millivolts.
	input  wire logic        pwm_ttl_pin,           // PWM comparator at TTL level.
	input  wire logic        pwm_plc_pin,           // PWM comparator at PLC level.
	input  wire logic        current_limit_active,  // Current limitation is engaged.
	input  wire logic        comm_step,             // One-cycle pulse per commutation step.
	output demand_type       demand,                // Set values and mode to the motor loop.
	output logic             current_limit_enable,  // Limitation enable to the current model.
	output logic             pulse_speed_output     // Digital output pin.
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		ctrl_type                ctrl;
		logic [15:0]             fixed_speed;
		logic [15:0]             max_speed;
		logic [23:0]             fault_delay;
		logic                    ttl_s1;
		logic                    ttl_s2;
		logic                    plc_s1;
		logic                    plc_s2;
		logic                    pwm_prev;
		logic [PWM_CNT_W-1:0]    hi_cnt;
		logic [PWM_CNT_W-1:0]    per_cnt;
		logic [PWM_CNT_W-1:0]    hi_lat;
		logic [PWM_CNT_W-1:0]    per_lat;
		logic                    pwm_run;
		logic                    qs_run;
		logic [15:0]             pwm_speed;
		demand_type              dem;
		logic [23:0]             fault_cnt;
		logic                    fault_q;
		logic [3:0]              step_div;
		logic                    freq_q;
		logic [STEP_CNT_W-1:0]   step_cnt;
		logic [STEP_CNT_W-1:0]   step_period;
		phase_type               phase;
		logic [31:0]             rdata;
		logic                    err;
	} state_type;

	state_type s_q;
	state_type s_d;

	logic        setup;
	logic        access;
	logic        addr_ok;
	logic        pwm_level;
	logic        fault_mode;
	logic [3:0]  toggle_every;
	logic [29:0] analog_prod;
	logic [29:0] volt_prod;
	logic [33:0] pwm_prod;
	logic [15:0] target;
	logic        run_req;

	// ==========================================================
	// Combinational helpers
	// ==========================================================
	// Bus phases; the slave never waits, so every access ends in its first access cycle.
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign addr_ok = (paddr == CTRL_ADDR) || (paddr == FIXED_ADDR) || (paddr == MAXSPD_ADDR) ||
	                 (paddr == FDELAY_ADDR) || (paddr == STATUS_ADDR) ||
	                 (paddr == PERIOD_ADDR) || (paddr == DEMAND_ADDR);

	// Only the second synchroniser stage is looked at.
	assign pwm_level = s_q.ctrl.plc_level ? s_q.plc_s2 : s_q.ttl_s2;

	// Without Hall sensors the fault selection is ignored.
	assign fault_mode = s_q.ctrl.fault_out & ~s_q.ctrl.sensorless;

	// Six lines toggle every step; two lines toggle every third step of a 12-step turn.
	assign toggle_every = s_q.ctrl.lines6 ? 4'(STEPS_PER_REV / 12) : 4'(STEPS_PER_REV / 4);

	// Linear scalings against the 10 V full scale and, for PWM, the latched period.
	assign analog_prod = 30'(s_q.max_speed) * 30'(setpoint_input_voltage);
	assign volt_prod   = 30'(supply_voltage_mv) * 30'(setpoint_input_voltage);
	assign pwm_prod    = 34'(s_q.max_speed) * 34'(s_q.hi_lat);

	// Speed target and run request by source.
	always_comb
	begin
		target  = 16'h0_000;
		run_req = 1'b0;
		case (s_q.ctrl.src)
			SRC_FIXED:
			begin
				target  = s_q.fixed_speed;
				run_req = s_q.qs_run;
			end
			SRC_ANALOG:
			begin
				target  = 16'(analog_prod / FULL_SCALE_MV);
				run_req = 1'b1;
			end
			SRC_PWM:
			begin
				target  = s_q.pwm_speed;
				run_req = s_q.pwm_run;
			end
			default:
			begin
				target  = 16'h0_000;
				run_req = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		s_d = s_q;

		// Two flip-flops on each PWM comparator pin.
		s_d.ttl_s1 = pwm_ttl_pin;
		s_d.ttl_s2 = s_q.ttl_s1;
		s_d.plc_s1 = pwm_plc_pin;
		s_d.plc_s2 = s_q.plc_s1;

		// Register writes land in the access cycle; reads are latched in setup.
		s_d.err = 1'b0;
		if (setup)
		begin
			s_d.err   = ~addr_ok;
			s_d.rdata = 32'h0000_0000;
			case (paddr)
				CTRL_ADDR:   s_d.rdata = 32'(s_q.ctrl);
				FIXED_ADDR:  s_d.rdata = 32'(s_q.fixed_speed);
				MAXSPD_ADDR: s_d.rdata = 32'(s_q.max_speed);
				FDELAY_ADDR: s_d.rdata = 32'(s_q.fault_delay);
				STATUS_ADDR: s_d.rdata = {26'h00_0000, s_q.phase, s_q.fault_q, s_q.pwm_run,
				                          s_q.qs_run, s_q.dem.run};
				PERIOD_ADDR: s_d.rdata = 32'(s_q.step_period);
				DEMAND_ADDR: s_d.rdata = {s_q.dem.voltage_mv, s_q.dem.speed};
				default:     s_d.rdata = 32'h0000_0000;
			endcase
		end
		else if (access)
		begin
			s_d.err = s_q.err;
		end
		if (access && pwrite)
		begin
			case (paddr)
				CTRL_ADDR:   s_d.ctrl        = ctrl_type'(pwdata[CTRL_WIDTH-1:0]);
				FIXED_ADDR:  s_d.fixed_speed = pwdata[15:0];
				MAXSPD_ADDR: s_d.max_speed   = pwdata[15:0];
				FDELAY_ADDR: s_d.fault_delay = pwdata[23:0];
				default:     s_d.ctrl        = s_q.ctrl;
			endcase
		end

		// Quick-stop levels with hysteresis; an open input stops or runs by polarity.
		case (s_q.ctrl.qs_mode)
			QS_NORMAL:
			begin
				if (setpoint_open || setpoint_input_voltage < QS_STOP_MV)
					s_d.qs_run = 1'b0;
				else if (setpoint_input_voltage >
				         (s_q.ctrl.sensorless ? QS_START_SL_MV : QS_START_MV))
					s_d.qs_run = 1'b1;
			end
			QS_INVERT:
			begin
				if (setpoint_open || setpoint_input_voltage < QSI_RUN_MV)
					s_d.qs_run = 1'b1;
				else if (setpoint_input_voltage > QSI_STOP_MV)
					s_d.qs_run = 1'b0;
			end
			default:
				s_d.qs_run = 1'b1;
		endcase

		// Duty measurement in clocks; a period ends at each rising edge.
		s_d.pwm_prev = pwm_level;
		if (pwm_level && !s_q.pwm_prev)
		begin
			s_d.hi_lat  = s_q.hi_cnt;
			s_d.per_lat = s_q.per_cnt;
			s_d.hi_cnt  = PWM_CNT_W'(1);
			s_d.per_cnt = PWM_CNT_W'(1);
			if (32'(s_q.hi_cnt) * PER_MILLE < 32'(s_q.per_cnt) * DUTY_STOP_PM)
				s_d.pwm_run = 1'b0;
			else if (32'(s_q.hi_cnt) * PER_MILLE > 32'(s_q.per_cnt) * DUTY_START_PM)
				s_d.pwm_run = 1'b1;
		end
		else
		begin
			if (s_q.per_cnt != PWM_CNT_W'(PWM_MAX_CYCLES))
				s_d.per_cnt = s_q.per_cnt + PWM_CNT_W'(1);
			if (pwm_level && s_q.hi_cnt != PWM_CNT_W'(PWM_MAX_CYCLES))
				s_d.hi_cnt = s_q.hi_cnt + PWM_CNT_W'(1);
			// A stuck line stops the motor when low and is full duty when high.
			if (s_q.per_cnt == PWM_CNT_W'(PWM_MAX_CYCLES))
			begin
				s_d.pwm_run = pwm_level;
				s_d.hi_lat  = pwm_level ? s_q.per_cnt : PWM_CNT_W'(0);
				s_d.per_lat = s_q.per_cnt;
			end
		end
		// The speed follows the latched period, once per completed period.
		s_d.pwm_speed = (s_q.per_lat == PWM_CNT_W'(0)) ? 16'h0_000 :
		                16'(pwm_prod / s_q.per_lat);

		// Commutation step spacing gives the actual speed in every sensor mode.
		if (comm_step)
		begin
			s_d.step_period = s_q.step_cnt;
			s_d.step_cnt    = STEP_CNT_W'(1);
		end
		else if (s_q.step_cnt != {STEP_CNT_W{1'b1}})
		begin
			s_d.step_cnt = s_q.step_cnt + STEP_CNT_W'(1);
		end

		// Sensorless start and low speed run on an imposed field.
		case (s_q.phase)
			PH_STOP:
				if (run_req)
					s_d.phase = s_q.ctrl.sensorless ? PH_FIELD : PH_CLOSED;
			PH_FIELD:
				if (!run_req)
					s_d.phase = PH_STOP;
				else if (!s_q.ctrl.sensorless || target >= FIELD_SPEED)
					s_d.phase = PH_CLOSED;
			PH_CLOSED:
				if (!run_req)
					s_d.phase = PH_STOP;
				else if (s_q.ctrl.sensorless && target < FIELD_SPEED)
					s_d.phase = PH_FIELD;
			default:
				s_d.phase = PH_STOP;
		endcase

		// Demand to the motor loop.
		s_d.dem.speed          = run_req ? target : 16'h0_000;
		s_d.dem.voltage_mv     = (run_req && s_q.ctrl.volt_mode) ?
		                         16'(volt_prod / FULL_SCALE_MV) : 16'h0_000;
		s_d.dem.run            = run_req;
		s_d.dem.four_quadrant  = s_q.ctrl.analog_hall & ~s_q.ctrl.sensorless;
		s_d.dem.brake          = s_q.ctrl.brake & ~s_d.dem.four_quadrant &
		                         ~run_req;
		s_d.dem.rotating_field = (s_q.phase == PH_FIELD);

		// Fault output: delayed rise, immediate fall.
		if (!current_limit_active)
		begin
			s_d.fault_cnt = 24'h00_0000;
			s_d.fault_q   = 1'b0;
		end
		else if (s_q.fault_cnt >= s_q.fault_delay)
		begin
			s_d.fault_q = 1'b1;
		end
		else
		begin
			s_d.fault_cnt = s_q.fault_cnt + 24'h00_0001;
		end

		// Frequency output toggles on every few commutation steps.
		if (comm_step)
		begin
			if (s_q.step_div + 4'h1 >= toggle_every)
			begin
				s_d.step_div = 4'h0;
				s_d.freq_q   = ~s_q.freq_q;
			end
			else
			begin
				s_d.step_div = s_q.step_div + 4'h1;
			end
		end
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q             <= '0;
			s_q.ctrl        <= ctrl_type'(CTRL_RESET);
			s_q.fixed_speed <= FIXED_RESET;
			s_q.max_speed   <= MAXSPD_RESET;
			s_q.fault_delay <= FDELAY_RESET;
			s_q.phase       <= PH_STOP;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Limitation is never switched off, whatever the mode.
	assign current_limit_enable = 1'b1;
	assign demand               = s_q.dem;
	assign pulse_speed_output   = fault_mode ? s_q.fault_q : s_q.freq_q;
	assign prdata               = s_q.rdata;
	assign pready               = 1'b1;
	assign pslverr              = access & s_q.err;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	fault_fall_low_a: assert property (
		fault_mode && !current_limit_active && $stable(s_q.ctrl) |=> !pulse_speed_output)
		else $error("Fault output did not fall with limitation.");
	fault_delay_hold_a: assert property (
		$rose(current_limit_active) && s_q.fault_delay == 24'h00_0005 && fault_mode
		##1 (current_limit_active && $stable(s_q.fault_delay) && fault_mode) [*5]
		|-> !pulse_speed_output ##1 (!current_limit_active || pulse_speed_output))
		else $error("Fault output delay wrong.");
	pwm_low_stop_a: assert property (
		pwm_level && !s_q.pwm_prev &&
		32'(s_q.hi_cnt) * 1000 < 32'(s_q.per_cnt) * 20 |=> !s_q.pwm_run)
		else $error("Low duty did not stop.");
	pwm_high_start_a: assert property (
		pwm_level && !s_q.pwm_prev &&
		32'(s_q.hi_cnt) * 1000 > 32'(s_q.per_cnt) * 30 |=> s_q.pwm_run)
		else $error("High duty did not start.");
	pwm_hysteresis_a: assert property (
		!(pwm_level && !s_q.pwm_prev) && s_q.per_cnt != PWM_CNT_W'(PWM_MAX_CYCLES)
		|=> $stable(s_q.pwm_run))
		else $error("PWM run changed mid period.");
	qs_open_stop_a: assert property (
		s_q.ctrl.qs_mode == QS_NORMAL && setpoint_open && $stable(s_q.ctrl)
		|=> !s_q.qs_run)
		else $error("Open input did not stop.");
	qs_inv_stop_a: assert property (
		s_q.ctrl.qs_mode == QS_INVERT && !setpoint_open &&
		setpoint_input_voltage > 14'd2400 && $stable(s_q.ctrl) |=> !s_q.qs_run)
		else $error("Inverted input did not stop.");
	fixed_speed_a: assert property (
		s_q.ctrl.src == SRC_FIXED && s_q.qs_run |=> demand.speed == $past(s_q.fixed_speed))
		else $error("Fixed speed not applied.");
	analog_scale_a: assert property (
		s_q.ctrl.src == SRC_ANALOG && setpoint_input_voltage == 14'd10000
		|=> demand.speed == $past(s_q.max_speed))
		else $error("Analog full scale wrong.");
	sensorless_out_a: assert property (
		s_q.ctrl.sensorless |-> pulse_speed_output == s_q.freq_q)
		else $error("Sensorless output not frequency.");
	field_start_a: assert property (
		s_q.phase == PH_STOP && run_req && s_q.ctrl.sensorless |=> s_q.phase == PH_FIELD)
		else $error("Sensorless start skipped field.");

	pwm_run_c:    cover property (s_q.ctrl.src == SRC_PWM ##1 $rose(s_q.pwm_run));
	fault_rise_c: cover property (fault_mode ##1 $rose(pulse_speed_output));
	field_to_closed_c: cover property (s_q.phase == PH_FIELD ##1 s_q.phase == PH_CLOSED);

endmodule

`default_nettype wire

// File: dv/pwm_partner.sv
// Partner model: a supervisory controller that feeds a PWM set value.
`timescale 1ns/1ps
`default_nettype none
module pwm_partner (
	input  wire logic        clk,     // System clock.
	input  wire logic        rst_n,   // Reset, active low.
	input  wire logic [17:0] per,     // Period in clocks.
	input  wire logic [17:0] hi,      // High time in clocks.
	input  wire logic        plc_sig, // Swing reaches the PLC level.
	output logic             ttl_pin, // TTL comparator output.
	output logic             plc_pin  // PLC comparator output.
);
	logic [17:0] cnt_q;
	logic [17:0] hi_q;
	// ==========
	// Period counter; the period never changes, only the duty.
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) cnt_q <= '0;
		else if (cnt_q >= per - 18'h0_0001) cnt_q <= '0;
		else cnt_q <= cnt_q + 18'h0_0001;
	// Duty is taken only at a period start, so no period is ever cut short.
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) hi_q <= '0;
		else if (cnt_q == '0) hi_q <= hi;
	// A TTL swing stays below the PLC threshold, so that comparator sees low.
	assign ttl_pin = cnt_q < hi_q;
	assign plc_pin = plc_sig & ttl_pin;
endmodule
`default_nettype wire

// File: dv/tb_bldc_setpoint_and_output_logic.sv
// Self-checking bench for the set-value and output block.
`timescale 1ns/1ps
`default_nettype none
module tb_bldc_setpoint_and_output_logic import setpoint_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, setpoint_open, plc_sig, err;
	logic        pwm_ttl_pin, pwm_plc_pin, current_limit_active, comm_step;
	logic        pready, pslverr, current_limit_enable, pulse_speed_output;
	logic [7:0]  paddr;
	logic [13:0] setpoint_input_voltage;
	logic [15:0] supply_voltage_mv;
	logic [17:0] hi;
	logic [31:0] pwdata, prdata, rv, m, v;
	demand_type  demand;
	int          fail_count, compares, tog;
	logic [7:0]  ra[4] = '{CTRL_ADDR, FIXED_ADDR, MAXSPD_ADDR, FDELAY_ADDR};
	int          rx[4] = '{'h101, 1000, 4000, 0};
	int          qc[14] = '{'h104, 'h104, 'h104, 'h104, 'h104, 'h108, 'h108, 'h108, 'h108,
	                        'h108, 'h100, 'h114, 'h114, 'h114};
	int          qv[14] = '{100, 200, 400, 200, 400, 3000, 2200, 1000, 2200, 3000, 3000, 100,
	                        400, 600};
	bit          qo[14] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 1, 0, 0, 0, 0};
	bit          qr[14] = '{0, 0, 1, 1, 0, 0, 0, 1, 1, 1, 1, 0, 0, 1};
	int          ph[5] = '{175, 245, 175, 105, 3500};
	bit          pr[5] = '{0, 1, 1, 0, 1};
	// ==========
	// Device and partner.
	bldc_setpoint_and_output_logic dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .setpoint_input_voltage(setpoint_input_voltage),
		.setpoint_open(setpoint_open), .supply_voltage_mv(supply_voltage_mv),
		.pwm_ttl_pin(pwm_ttl_pin), .pwm_plc_pin(pwm_plc_pin), .comm_step(comm_step),
		.current_limit_active(current_limit_active), .demand(demand),
		.current_limit_enable(current_limit_enable), .pulse_speed_output(pulse_speed_output));
	pwm_partner u_src (.clk(pclk), .rst_n(presetn), .per(18'h0_1B58), .hi(hi),
		.plc_sig(plc_sig), .ttl_pin(pwm_ttl_pin), .plc_pin(pwm_plc_pin));
	// Clock at 125 MHz and an edge counter on the digital output.
	always #4 pclk = ~pclk;
	always @(pulse_speed_output) tog++;
	// ==========
	// Helpers.
	function automatic logic [31:0] scale(input logic [31:0] a, b, d);
		return a * b / d;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer; waits for pready rather than assuming a latency.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Rounding inside the block may differ by a unit, hence the tolerance.
	task automatic cmp(input logic [31:0] g, input logic [31:0] x, input int t);
		compares++;
		if (g !== x && ($isunknown(g) || (g > x ? g - x : x - g) > t))
		begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic steps();
		repeat (12)
		begin
			comm_step <= 1'b1;
			cyc(1);
			comm_step <= 1'b0;
			cyc(2);
		end
	endtask
	task automatic report_and_stop();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog sized above the long PWM section.
	initial
	begin
		repeat (100000) @(posedge pclk);
		fail_count++;
		report_and_stop();
	end
	// ==========
	// Main sequence.
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, setpoint_open, plc_sig, comm_step} = '0;
		{current_limit_active, paddr, pwdata, setpoint_input_voltage, hi} = '0;
		supply_voltage_mv = 16'h5DC0;
		void'($urandom(1229));
		cyc(2);
		presetn <= 1'b1;
		foreach (ra[i])
		begin
			apb(1'b0, ra[i], '0);
			cmp(rv, 32'(rx[i]), 0);
		end
		apb(1'b0, 8'h1C, '0);
		cmp(32'(err), 32'h0000_0001, 0);
		for (int k = 0; k < 4; k++)
		begin
			m = $urandom_range(65535);
			v = (k == 0) ? 10000 : $urandom_range(10000);
			apb(1'b1, MAXSPD_ADDR, m);
			setpoint_input_voltage <= v[13:0];
			cyc(4);
			cmp(32'(demand.speed), scale(m, v, 10000), 1);
			cmp(32'(demand.run), 32'h0000_0001, 0);
		end
		apb(1'b1, CTRL_ADDR, 32'h0000_0161);
		setpoint_input_voltage <= 14'h1388;
		cyc(4);
		cmp(32'(demand.voltage_mv), scale(24000, 5000, 10000), 1);
		cmp(32'(current_limit_enable), 32'h0000_0001, 0);
		cmp(32'(demand.four_quadrant), 32'h0000_0001, 0);
		apb(1'b1, FIXED_ADDR, 32'h0000_FFFF);
		apb(1'b0, FIXED_ADDR, '0);
		cmp(rv, 32'h0000_FFFF, 0);
		foreach (qv[i])
		begin
			apb(1'b1, CTRL_ADDR, 32'(qc[i]));
			setpoint_input_voltage <= 14'(qv[i]);
			setpoint_open <= qo[i];
			cyc(4);
			cmp(32'(demand.run), 32'(qr[i]), 0);
		end
		cmp(32'(demand.speed), 32'h0000_FFFF, 0);
		apb(1'b1, CTRL_ADDR, 32'h0000_0504);
		setpoint_open <= 1'b1;
		cyc(4);
		cmp(32'(demand.brake), 32'h0000_0001, 0);
		setpoint_open <= 1'b0;
		apb(1'b1, FDELAY_ADDR, 32'h0000_0005);
		apb(1'b1, CTRL_ADDR, 32'h0000_0181);
		current_limit_active <= 1'b1;
		cyc(5);
		cmp(32'(pulse_speed_output), 32'h0000_0000, 0);
		cyc(3);
		cmp(32'(pulse_speed_output), 32'h0000_0001, 0);
		current_limit_active <= 1'b0;
		cyc(3);
		cmp(32'(pulse_speed_output), 32'h0000_0000, 0);
		apb(1'b1, MAXSPD_ADDR, 32'h0000_0FA0);
		current_limit_active <= 1'b1;
		apb(1'b1, CTRL_ADDR, 32'h0000_0191);
		cyc(2);
		tog = 0;
		steps();
		cmp(32'(tog), 32'h0000_000C, 0);
		apb(1'b1, CTRL_ADDR, 32'h0000_0091);
		cyc(2);
		tog = 0;
		steps();
		cmp(32'(tog), 32'h0000_0004, 0);
		apb(1'b0, PERIOD_ADDR, '0);
		cmp(rv, 32'h0000_0003, 0);
		cmp(32'(demand.rotating_field), 32'h0000_0001, 0);
		setpoint_input_voltage <= 14'h2710;
		cyc(3);
		cmp(32'(demand.rotating_field), 32'h0000_0000, 0);
		current_limit_active <= 1'b0;
		foreach (ph[i])
		begin
			apb(1'b1, CTRL_ADDR, (i == 4) ? 32'h0000_0302 : 32'h0000_0102);
			plc_sig <= (i == 4);
			hi <= 18'(ph[i]);
			cyc(14020);
			cmp(32'(demand.run), 32'(pr[i]), 0);
		end
		cmp(32'(demand.speed), 32'h0000_07D0, 2);
		report_and_stop();
	end
endmodule
`default_nettype wire
